// *** rtl/cfs_pkg.sv ***
// Purpose: Shared constants and types for the port 0 frame and line statistics bank
// Assumes: 8-bit register bus with byte addresses
// Notes:   Offsets are the register addresses as seen on the register port
package cfs_pkg;

    localparam int unsigned TALLY_W = 16;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned ADDR_W  = 8;

    localparam logic [7:0] ADDR_FRAMES_HIGH     = 8'h90;
    localparam logic [7:0] ADDR_FRAMES_LOW      = 8'h91;
    localparam logic [7:0] ADDR_BAD_FRAMES_HIGH = 8'h92;
    localparam logic [7:0] ADDR_BAD_FRAMES_LOW  = 8'h93;
    localparam logic [7:0] ADDR_LINES_HIGH      = 8'h94;
    localparam logic [7:0] ADDR_LINES_LOW       = 8'h95;

    localparam logic [15:0] TALLY_RESET = 16'h0000;
    localparam logic [15:0] TALLY_ONE   = 16'h0001;
    localparam logic [15:0] TALLY_FULL  = 16'hffff;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [7:0]  UNMAPPED    = 8'h00;

    // One counter together with its captured low byte
    typedef struct packed {
        logic [15:0] tally;
        logic [7:0]  lowSnap;
    } cfs_counter_t;

    typedef struct packed {
        cfs_counter_t frames;
        cfs_counter_t badFrames;
        cfs_counter_t lines;
        logic [7:0]   readData;
    } cfs_state_t;

    // Register port request
    typedef struct packed {
        logic       rd;
        logic [7:0] addr;
    } cfs_req_t;

    // Events seen on output port 0, one-cycle pulses
    typedef struct packed {
        logic frameDone;
        logic frameErr;
        logic lineDone;
    } cfs_event_t;

endpackage

// *** rtl/cfs_port0_stats.sv ***
// Purpose: Frame, errored frame and line statistics for CSI-2 output port 0
// Assumes: Register reads arrive as one-cycle strobes synchronous to clock
// Notes:   Read data is registered and valid the cycle after the strobe
//          High reads clear their counter; low reads have no side effect
//          Events are single-cycle pulses counted on every edge
`timescale 1ns/1ps

module cfs_port0_stats (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // Register port
    input  wire cfs_pkg::cfs_req_t  regReq,
    output logic [7:0]              regReadData,
    // Port 0 events
    input  wire cfs_pkg::cfs_event_t portEvent
);

    ////////////////////////////////////////////////////////////////////////////
    // Registered state and its next value
    ////////////////////////////////////////////////////////////////////////////

    cfs_pkg::cfs_state_t state;
    cfs_pkg::cfs_state_t next_state;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded register strobes and qualified events
    ////////////////////////////////////////////////////////////////////////////

    // High reads snapshot and clear their counter
    logic rdFramesHigh;
    logic rdBadHigh;
    logic rdLinesHigh;

    // Low reads only return the snapshot
    logic rdFramesLow;
    logic rdBadLow;
    logic rdLinesLow;

    // Reads outside the bank
    logic rdUnmapped;

    // Events as counted; the two frame events are independent
    logic countFrame;
    logic countBad;
    logic countLine;

    ////////////////////////////////////////////////////////////////////////////
    // Address match
    ////////////////////////////////////////////////////////////////////////////

    // True when this request reads the given register
    function automatic logic hits(
        input cfs_pkg::cfs_req_t req,
        input logic [7:0]        addr
    );
        logic res;

        res = req.rd && (req.addr == addr);

        return res;
    endfunction

    // True for an address inside the bank
    function automatic logic inBank(
        input logic [7:0] addr
    );
        logic res;

        unique case (addr)
            cfs_pkg::ADDR_FRAMES_HIGH,
            cfs_pkg::ADDR_FRAMES_LOW,
            cfs_pkg::ADDR_BAD_FRAMES_HIGH,
            cfs_pkg::ADDR_BAD_FRAMES_LOW,
            cfs_pkg::ADDR_LINES_HIGH,
            cfs_pkg::ADDR_LINES_LOW: begin
                res = 1'b1;
            end
            default: begin
                res = 1'b0;
            end
        endcase

        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Byte lanes of a tally
    ////////////////////////////////////////////////////////////////////////////

    // Upper byte, as returned by a high read
    function automatic logic [7:0] upperByte(
        input logic [15:0] tally
    );
        logic [7:0] res;

        res = tally[15:8];

        return res;
    endfunction

    // Lower byte, as kept by the snapshot
    function automatic logic [7:0] lowerByte(
        input logic [15:0] tally
    );
        logic [7:0] res;

        res = tally[7:0];

        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Counter arithmetic
    ////////////////////////////////////////////////////////////////////////////

    // Saturating increment; a wrap would make a busy port look idle
    function automatic logic [15:0] bump(
        input logic [15:0] tally
    );
        logic [15:0] res;

        res = tally;
        if (tally != cfs_pkg::TALLY_FULL) begin
            res = tally + cfs_pkg::TALLY_ONE;
        end

        return res;
    endfunction

    // Value left by a clearing read; an event in that cycle is kept
    function automatic logic [15:0] clearValue(
        input logic ev
    );
        logic [15:0] res;

        if (ev) begin
            res = cfs_pkg::TALLY_ONE;
        end else begin
            res = cfs_pkg::TALLY_RESET;
        end

        return res;
    endfunction

    // Next counter after one cycle: read-clear, count or hold
    function automatic cfs_pkg::cfs_counter_t step(
        input cfs_pkg::cfs_counter_t cur,
        input logic                  ev,
        input logic                  clearRd
    );
        cfs_pkg::cfs_counter_t res;

        res = cur;
        if (clearRd) begin
            res.lowSnap = lowerByte(cur.tally);
            res.tally   = clearValue(ev);
        end else if (ev) begin
            res.tally = bump(cur.tally);
        end

        return res;
    endfunction

    // Counter and snapshot as left by reset
    function automatic cfs_pkg::cfs_counter_t resetCounter();
        cfs_pkg::cfs_counter_t res;

        res.tally   = cfs_pkg::TALLY_RESET;
        res.lowSnap = cfs_pkg::BYTE_RESET;

        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    ////////////////////////////////////////////////////////////////////////////

    assign rdFramesHigh = hits(
        regReq,
        cfs_pkg::ADDR_FRAMES_HIGH
    );

    assign rdFramesLow = hits(
        regReq,
        cfs_pkg::ADDR_FRAMES_LOW
    );

    assign rdBadHigh = hits(
        regReq,
        cfs_pkg::ADDR_BAD_FRAMES_HIGH
    );

    assign rdBadLow = hits(
        regReq,
        cfs_pkg::ADDR_BAD_FRAMES_LOW
    );

    assign rdLinesHigh = hits(
        regReq,
        cfs_pkg::ADDR_LINES_HIGH
    );

    assign rdLinesLow = hits(
        regReq,
        cfs_pkg::ADDR_LINES_LOW
    );

    // Anything else reads as zero and touches no counter
    assign rdUnmapped = regReq.rd
        && !inBank(regReq.addr);

    ////////////////////////////////////////////////////////////////////////////
    // Event qualification
    ////////////////////////////////////////////////////////////////////////////

    // Events are taken on every edge that they are high
    assign countFrame = portEvent.frameDone;
    assign countBad   = portEvent.frameErr;
    assign countLine  = portEvent.lineDone;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_state = state;

        // Frames sent
        next_state.frames = step(
            state.frames,
            countFrame,
            rdFramesHigh
        );

        // Frames that carried errors
        next_state.badFrames = step(
            state.badFrames,
            countBad,
            rdBadHigh
        );

        // Lines sent
        next_state.lines = step(
            state.lines,
            countLine,
            rdLinesHigh
        );

        // Read data holds between reads
        if (rdFramesHigh) begin
            next_state.readData = upperByte(state.frames.tally);
        end else if (rdFramesLow) begin
            next_state.readData = state.frames.lowSnap;
        end else if (rdBadHigh) begin
            next_state.readData = upperByte(state.badFrames.tally);
        end else if (rdBadLow) begin
            next_state.readData = state.badFrames.lowSnap;
        end else if (rdLinesHigh) begin
            next_state.readData = upperByte(state.lines.tally);
        end else if (rdLinesLow) begin
            next_state.readData = state.lines.lowSnap;
        end else if (rdUnmapped) begin
            next_state.readData = cfs_pkg::UNMAPPED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clock) begin
        if (rst) begin
            state.frames    <= resetCounter();
            state.badFrames <= resetCounter();
            state.lines     <= resetCounter();
            state.readData  <= cfs_pkg::BYTE_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    assign regReadData = state.readData;

endmodule // cfs_port0_stats

// *** testbench/cfs_port0_stats_sva.sv ***
// Purpose: Port checks for the port 0 statistics bank
// Assumes: Read data answers one cycle after the strobe
// Notes:   Clear checks need no event at the first read
`timescale 1ns/1ps
module cfs_port0_stats_sva (
    // Clock and reset
    input wire logic                clock,
    input wire logic                rst,
    // Register port and events
    input wire cfs_pkg::cfs_req_t   regReq,
    input wire logic [7:0]          regReadData,
    input wire cfs_pkg::cfs_event_t portEvent
);
    wire [7:0] a = regReq.addr;
    wire [7:0] d = regReadData;
    wire [2:0] e = portEvent;
    wire       u = regReq.rd && (a < 8'h90 || a > 8'h95);
    wire [2:0] h = {3{regReq.rd}} & {a == 8'h90, a == 8'h92, a == 8'h94};
    wire [2:0] l = {3{regReq.rd}} & {a == 8'h91, a == 8'h93, a == 8'h95};
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    AST_RST: assert property ($fell(rst) |-> d == 8'h00) else $error("reset");
    AST_UNMAP: assert property (u |=> d == 8'h00) else $error("unmapped");
    AST_CLRF: assert property (h[2] && !e[2] ##1 h[2] |=> d == 8'h00) else $error("f");
    AST_CLRE: assert property (h[1] && !e[1] ##1 h[1] |=> d == 8'h00) else $error("e");
    AST_CLRL: assert property (h[0] && !e[0] ##1 h[0] |=> d == 8'h00) else $error("l");
    AST_LOWF: assert property (h[2] && !e[2] ##1 h[2] ##1 l[2] |=> d == 8'h00) else $error("f");
    AST_LOWE: assert property (h[1] && !e[1] ##1 h[1] ##1 l[1] |=> d == 8'h00) else $error("e");
    AST_LOWL: assert property (h[0] && !e[0] ##1 h[0] ##1 l[0] |=> d == 8'h00) else $error("l");
endmodule // cfs_port0_stats_sva
bind cfs_port0_stats cfs_port0_stats_sva chk_u (.clock(clock), .rst(rst), .regReq(regReq),
    .regReadData(regReadData), .portEvent(portEvent));

// *** testbench/test_cfs_port0_stats.sv ***
// Purpose: Self-checking bench for the port 0 statistics bank
// Assumes: Events and reads change at the falling edge
// Notes:   Saturation costs about 65600 cycles
`timescale 1ns/1ps
module test_cfs_port0_stats;
    logic                clock = 1'b0;
    logic                rst = 1'b1;
    logic                sat = 1'b0;
    logic                took = 1'b0;
    cfs_pkg::cfs_req_t   regReq = '0;
    cfs_pkg::cfs_event_t portEvent = '0;
    logic [7:0]          regReadData;
    logic [15:0]         cnt [3];
    logic [7:0]          snap [3];
    logic [7:0]          q [$];
    logic [7:0]          want;
    int                  seed = 25;
    int                  badCount = 0;
    int                  checksDone = 0;
    always #2.5 clock = ~clock;
    cfs_port0_stats dut_u (.clock(clock), .rst(rst), .regReq(regReq),
        .regReadData(regReadData), .portEvent(portEvent));
    ////////////////////////////////////////
    always @(negedge clock) portEvent <= cfs_pkg::cfs_event_t'(3'($random(seed)) | {3{sat}});
    // Reference tallies; pre-clear high byte is answered, set wins over clear
    always @(posedge clock) begin
        took <= regReq.rd && !rst;
        for (int i = 0; i < 3; i++) begin
            if (!rst && regReq.rd && regReq.addr == 8'h94 - 8'(2 * i)) begin
                q.push_back(cnt[i][15:8]);
                snap[i] = cnt[i][7:0];
                cnt[i] = 16'h0000;
            end
            if (!rst && regReq.rd && regReq.addr == 8'h95 - 8'(2 * i)) q.push_back(snap[i]);
            if (portEvent[i] && cnt[i] != 16'hffff) cnt[i] = cnt[i] + 16'h0001;
            if (rst) {cnt[i], snap[i]} = 24'h000000;
        end
        if (!rst && regReq.rd && (regReq.addr < 8'h90 || regReq.addr > 8'h95)) q.push_back(8'h00);
    end
    always @(negedge clock) if (took) begin
        want = q.pop_front();
        checksDone++;
        if (regReadData !== want) begin
            badCount++;
            $display("unexpected at %0t: got %h want %h", $time, regReadData, want);
        end
    end
    task automatic rd(input logic [7:0] a);
        regReq <= '{1'b1, a};
        @(negedge clock);
    endtask
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        badCount++;
        printVerdict();
    end
    initial begin
        repeat (2) @(negedge clock);
        rst <= 1'b0;
        for (int n = 0; n < 10; n++) begin
            if (n == 8) sat <= 1'b1;
            repeat (n == 8 ? 65600 : 200) @(negedge clock);
            rd(8'(n * 7));
            for (int i = 0; i < 6; i++) rd(8'h90 + 8'(i == 5 ? 6 : i / 2 * 2 + (i % 2) * 0));
            for (int i = 0; i < 3; i++) begin
                rd(8'h90 + 8'(2 * i));
                rd(8'h90 + 8'(2 * i));
                rd(8'h91 + 8'(2 * i));
            end
            regReq <= '0;
            if (n == 9) rst <= 1'b1;
        end
        repeat (2) @(negedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) rd(8'h91 + 8'(2 * i));
        regReq <= '0;
        repeat (3) @(negedge clock);
        printVerdict();
    end
endmodule // test_cfs_port0_stats
